// [hdl/rtm_defs.vh]
/*
  constants for the room temperature measurement block: register byte
  offsets, control field positions, reset values and timing counts.
  assumes inclusion by bare name from files of this block only.
*/
`ifndef RTM_DEFS_VH
`define RTM_DEFS_VH

// register byte offsets on the apb bus
`define RTM_A_CTRL     8'h00
`define RTM_A_OFFSET   8'h04
`define RTM_A_STEP     8'h08
`define RTM_A_CYCLE    8'h0C
`define RTM_A_STATUS   8'h10
`define RTM_A_OBJECT   8'h14
`define RTM_A_LEARNED  8'h18

// control register fields
`define RTM_C_ENABLE   0
`define RTM_C_TGMODE   1
`define RTM_C_INV7FFF  2
`define RTM_C_READOK   3

// reset values
`define RTM_CTRL_RST   4'h0
`define RTM_OFS_RST    16'h0000
`define RTM_STEP_RST   8'h00
`define RTM_CYC_RST    8'h00

// temperatures are signed centikelvin
`define RTM_OFS_LIM    16'h07D0
`define RTM_CAL_WIN    17'h0_2710
`define RTM_STEP_MUL   17'h0_000A
`define RTM_INVALID    16'h7FFF

// timing
`define RTM_CLK_HZ     20000000
`define RTM_MINUTE_S   60

`endif

// [hdl/rtm_absdiff.v]
/*
  magnitude of the difference of two signed 16-bit temperatures.
  assumes purely combinational use inside the same clock domain.
*/
`timescale 1ns/100ps
module rtm_absdiff (
  input  wire [15:0] a,
  input  wire [15:0] b,
  output wire [16:0] mag
);
  wire signed [16:0] diff;

  // widen before subtracting so nothing wraps
  assign diff = $signed({a[15], a}) - $signed({b[15], b});
  assign mag  = diff[16] ? (17'h0_0000 - diff) : diff;
endmodule

// [hdl/rtm_min_timer.v]
/*
  period timer counting whole minutes, restartable.
  assumes one clock; minute length is a parameter for short simulations.
*/
`timescale 1ns/100ps
`include "rtm_defs.vh"
module rtm_min_timer #(
  parameter [31:0] MINUTE_CYC = `RTM_MINUTE_S * `RTM_CLK_HZ
) (
  input  wire       clk,
  input  wire       rst,
  input  wire       restart,
  input  wire [7:0] period,
  output reg        expired
);
  reg [31:0] cyc_q;
  reg [7:0]  min_q;

  // cycle prescaler and minute counter; period 0 never fires
  always @(posedge clk) begin
    expired <= 1'b0;
    if (rst || restart || period == 8'h00) begin
      cyc_q <= 32'h0000_0000;
      min_q <= 8'h00;
    end else if (cyc_q == MINUTE_CYC - 32'h0000_0001) begin
      cyc_q <= 32'h0000_0000;
      if (min_q + 8'h01 >= period) begin
        min_q   <= 8'h00;
        expired <= 1'b1;
      end else begin
        min_q <= min_q + 8'h01;
      end
    end else begin
      cyc_q <= cyc_q + 32'h0000_0001;
    end
  end
endmodule

// [hdl/rtm_top.v]
/*
  room temperature measurement: applies static or learned calibration to
  the sensor reading and publishes a 2-byte value on change, cyclically,
  at startup and on read. configuration over apb.
  assumes sensor samples, telegram strobes and nv store on the same clock.
*/
// Our own choices: the APB interface to the registers and the address map.
`timescale 1ns/100ps
`include "rtm_defs.vh"

//
// Operation
// - measure and publish only when enabled
// - static mode adds offset, clamped to 20 K
// - telegram mode ignores static offset
// - learned offset maps raw reading to reference
// - acknowledge calibration by sending calibrated value; a same-cycle STARTUP sends obj_d instead, if auto enabled
// - reject reference off by over 100 K
// - learned calibration kept in non-volatile store
// - telegram mode: no evaluation before calibration
// - uncalibrated output holds 0 or 7FFF
// - new calibration replaces; static mode resets it
// - send on change by configured step
// - send cyclically every 1 to 255 minutes
// - always publish calibrated value, never raw
// - refresh at startup, send if auto enabled
// - startup send ignores transmission delay
// - no auto sends disabled; read needs flag
// - publish temperature as 2-byte object
module rtm_top #(
  parameter [31:0] MINUTE_CYC = `RTM_MINUTE_S * `RTM_CLK_HZ
) (
  input  wire        CLK,
  input  wire        RST,
  input  wire        PSEL,
  input  wire        PENABLE,
  input  wire        PWRITE,
  input  wire [7:0]  PADDR,
  input  wire [31:0] PWDATA,
  output reg  [31:0] PRDATA,
  output reg         PREADY,
  output reg         PSLVERR,
  input  wire        SENSOR_VALID,
  input  wire [15:0] SENSOR_TEMP,
  input  wire        STARTUP,
  input  wire        CAL_VALID,
  input  wire [15:0] CAL_VALUE,
  input  wire        READ_REQ,
  input  wire        NV_LOAD,
  input  wire        NV_LOAD_OK,
  input  wire [15:0] NV_LOAD_OFS,
  output reg         NV_STORE,
  output reg         NV_STORE_OK,
  output reg  [15:0] NV_STORE_OFS,
  output reg         TX_SEND,
  output reg  [15:0] TX_VALUE,
  output reg         READ_RESP,
  output reg  [15:0] READ_VALUE
);
  localparam [1:0] ST_OFF  = 2'd0;
  localparam [1:0] ST_WAIT = 2'd1;
  localparam [1:0] ST_RUN  = 2'd2;

  reg  [3:0]  ctrl_q;
  reg  [15:0] ofs_q;
  reg  [7:0]  step_q;
  reg  [7:0]  cyc_q;
  reg  [15:0] raw_q;
  reg  [15:0] learn_q;
  reg         cal_ok_q;
  reg  [15:0] obj_q;
  reg  [15:0] last_q;
  reg         cyc_pend_q;
  reg  [1:0]  st_q;
  reg  [1:0]  st_d;
  reg  [15:0] ofs_lim;
  reg  [15:0] send_val;
  reg         send_now;
  wire        en;
  wire        tg;
  wire        auto_on;
  wire        apb_wr;
  wire        apb_rd;
  wire [16:0] sum;
  wire [15:0] cal_temp;
  wire [15:0] eff_ofs;
  wire [15:0] obj_d;
  wire [16:0] chg_mag;
  wire [16:0] ref_mag;
  wire [16:0] step_ck;
  wire        chg_hit;
  wire        chg_send;
  wire        cal_acc;
  wire        cyc_exp;

  assign en      = ctrl_q[`RTM_C_ENABLE];
  assign tg      = ctrl_q[`RTM_C_TGMODE];
  assign auto_on = (step_q != 8'h00) || (cyc_q != 8'h00);
  assign apb_wr  = PSEL & PENABLE & PREADY & PWRITE;
  assign apb_rd  = PSEL & PENABLE & ~PREADY & ~PWRITE;

  // static offset clamped to the allowed band
  always @* begin
    ofs_lim = ofs_q;
    if (!ofs_q[15] && ofs_q > `RTM_OFS_LIM)
      ofs_lim = `RTM_OFS_LIM;
    else if (ofs_q[15] && (16'h0000 - ofs_q) > `RTM_OFS_LIM)
      ofs_lim = 16'h0000 - `RTM_OFS_LIM;
  end

  // telegram mode uses only the learned offset
  assign eff_ofs  = tg ? learn_q : ofs_lim;
  assign sum      = $signed({raw_q[15], raw_q}) + $signed({eff_ofs[15], eff_ofs});
  assign cal_temp = sum[15:0];

  // object value: marker while uncalibrated
  assign obj_d = !en ? 16'h0000 :
                 (tg && !cal_ok_q) ?
                   (ctrl_q[`RTM_C_INV7FFF] ? `RTM_INVALID : 16'h0000) :
                   cal_temp;

  // change against last published value
  rtm_absdiff u_chg (
    .a   (cal_temp),
    .b   (last_q),
    .mag (chg_mag)
  );
  assign step_ck = {9'h000, step_q} * `RTM_STEP_MUL;
  assign chg_hit = (step_q != 8'h00) && (chg_mag >= step_ck);
  // state lags the mode bit by a cycle, so gate on calibration too
  assign chg_send = (st_q == ST_RUN) && !(tg && !cal_ok_q) && !SENSOR_VALID && chg_hit;

  // reference window against own measurement
  rtm_absdiff u_ref (
    .a   (CAL_VALUE),
    .b   (raw_q),
    .mag (ref_mag)
  );
  assign cal_acc = en && tg && CAL_VALID && (ref_mag <= `RTM_CAL_WIN);

  // periodic sending
  rtm_min_timer #(
    .MINUTE_CYC (MINUTE_CYC)
  ) u_cyc (
    .clk     (CLK),
    .rst     (RST),
    .restart (~en | STARTUP),
    .period  (cyc_q),
    .expired (cyc_exp)
  );

  // measurement state
  always @* begin
    st_d = st_q;
    case (st_q)
      ST_OFF:  if (en) st_d = (tg && !cal_ok_q) ? ST_WAIT : ST_RUN;
      ST_WAIT: if (!en) st_d = ST_OFF;
               else if (cal_acc || !tg) st_d = ST_RUN;
      ST_RUN:  if (!en) st_d = ST_OFF;
               else if (tg && !cal_ok_q) st_d = ST_WAIT;
      default: st_d = ST_OFF;
    endcase
  end

  // send selection: startup, acknowledge, change, cycle
  always @* begin
    send_now = 1'b0;
    send_val = obj_d;
    if (!en) begin
      send_now = 1'b0;
    end else if (STARTUP) begin
      send_now = auto_on;
    end else if (cal_acc) begin
      send_now = 1'b1;
      send_val = CAL_VALUE;
    end else if (chg_send) begin
      send_now = 1'b1;
    end else if (cyc_pend_q) begin
      send_now = 1'b1;
    end
  end

  // apb bus: one wait state, registered answer
  always @(posedge CLK) begin
    if (RST) begin
      PREADY  <= 1'b0;
      PSLVERR <= 1'b0;
      PRDATA  <= 32'h0000_0000;
    end else begin
      PREADY  <= PSEL & PENABLE & ~PREADY;
      PSLVERR <= 1'b0;
      if (PSEL & PENABLE & ~PREADY) begin
        PRDATA <= 32'h0000_0000;
        if (PADDR == `RTM_A_CTRL) begin
          if (apb_rd) PRDATA <= {28'h000_0000, ctrl_q};
        end else if (PADDR == `RTM_A_OFFSET) begin
          if (apb_rd) PRDATA <= {16'h0000, ofs_q};
        end else if (PADDR == `RTM_A_STEP) begin
          if (apb_rd) PRDATA <= {24'h00_0000, step_q};
        end else if (PADDR == `RTM_A_CYCLE) begin
          if (apb_rd) PRDATA <= {24'h00_0000, cyc_q};
        end else if (PADDR == `RTM_A_STATUS) begin
          if (apb_rd) PRDATA <= {28'h000_0000, st_q, 1'b0, cal_ok_q};
        end else if (PADDR == `RTM_A_OBJECT) begin
          if (apb_rd) PRDATA <= {16'h0000, obj_q};
        end else if (PADDR == `RTM_A_LEARNED) begin
          if (apb_rd) PRDATA <= {16'h0000, learn_q};
        end else begin
          PSLVERR <= 1'b1;
        end
      end
    end
  end

  // configuration registers
  always @(posedge CLK) begin
    if (RST) begin
      ctrl_q <= `RTM_CTRL_RST;
      ofs_q  <= `RTM_OFS_RST;
      step_q <= `RTM_STEP_RST;
      cyc_q  <= `RTM_CYC_RST;
    end else if (apb_wr) begin
      if (PADDR == `RTM_A_CTRL)
        ctrl_q <= PWDATA[3:0];
      else if (PADDR == `RTM_A_OFFSET)
        ofs_q <= PWDATA[15:0];
      else if (PADDR == `RTM_A_STEP)
        step_q <= PWDATA[7:0];
      else if (PADDR == `RTM_A_CYCLE)
        cyc_q <= PWDATA[7:0];
    end
  end

  // learned calibration and its persistent copy
  always @(posedge CLK) begin
    if (RST) begin
      learn_q      <= 16'h0000;
      cal_ok_q     <= 1'b0;
      NV_STORE     <= 1'b0;
      NV_STORE_OK  <= 1'b0;
      NV_STORE_OFS <= 16'h0000;
    end else begin
      NV_STORE <= 1'b0;
      if (cal_acc) begin
        learn_q      <= CAL_VALUE - raw_q;
        cal_ok_q     <= 1'b1;
        NV_STORE     <= 1'b1;
        NV_STORE_OK  <= 1'b1;
        NV_STORE_OFS <= CAL_VALUE - raw_q;
      end else if (en && !tg && cal_ok_q) begin
        learn_q      <= 16'h0000;
        cal_ok_q     <= 1'b0;
        NV_STORE     <= 1'b1;
        NV_STORE_OK  <= 1'b0;
        NV_STORE_OFS <= 16'h0000;
      end else if (NV_LOAD) begin
        learn_q  <= NV_LOAD_OFS;
        cal_ok_q <= NV_LOAD_OK;
      end
    end
  end

  // sensor sample, object value, state and sending
  always @(posedge CLK) begin
    if (RST) begin
      raw_q      <= 16'h0000;
      obj_q      <= 16'h0000;
      last_q     <= 16'h0000;
      cyc_pend_q <= 1'b0;
      st_q       <= ST_OFF;
      TX_SEND    <= 1'b0;
      TX_VALUE   <= 16'h0000;
      READ_RESP  <= 1'b0;
      READ_VALUE <= 16'h0000;
    end else begin
      st_q      <= st_d;
      TX_SEND   <= send_now;
      READ_RESP <= 1'b0;
      if (en && SENSOR_VALID)
        raw_q <= SENSOR_TEMP;
      obj_q <= cal_acc ? CAL_VALUE : obj_d;
      if (send_now) begin
        TX_VALUE <= send_val;
        last_q   <= send_val;
      end
      // cycle pending survives a higher priority send
      if (send_now && !STARTUP && !cal_acc && !chg_send)
        cyc_pend_q <= cyc_exp;
      else if (!en)
        cyc_pend_q <= 1'b0;
      else if (cyc_exp)
        cyc_pend_q <= 1'b1;
      if (READ_REQ && en && ctrl_q[`RTM_C_READOK]) begin
        READ_RESP  <= 1'b1;
        READ_VALUE <= obj_d;
      end
    end
  end
endmodule

// [testbench/rtm_top_props.sv]
/*
  assertions on the ports of rtm_top, bound after the module.
  assumes one clock and a synchronous active-high reset.
*/
`timescale 1ns/100ps
module rtm_top_props #(
  parameter [31:0] MINUTE_CYC = 32'h0000_0014
) (
  input wire        CLK,
  input wire        RST,
  input wire        PSEL,
  input wire        PENABLE,
  input wire        PREADY,
  input wire        SENSOR_VALID,
  input wire [15:0] SENSOR_TEMP,
  input wire        CAL_VALID,
  input wire [15:0] CAL_VALUE,
  input wire        READ_REQ,
  input wire        NV_STORE,
  input wire        NV_STORE_OK,
  input wire [15:0] NV_STORE_OFS,
  input wire        TX_SEND,
  input wire [15:0] TX_VALUE,
  input wire        READ_RESP
);
  reg  [15:0]        raw_q;
  wire signed [16:0] gap = $signed({CAL_VALUE[15], CAL_VALUE}) - $signed({raw_q[15], raw_q});
  wire               far = (gap > 17'sd10000) || (gap < -17'sd10000);

  // last raw sample, the reference for the calibration window
  always @(posedge CLK) begin
    if (RST)
      raw_q <= 16'h0000;
    else if (SENSOR_VALID)
      raw_q <= SENSOR_TEMP;
  end

  default clocking @(posedge CLK); endclocking
  default disable iff (RST);

  chk_apb_wait: assert property (PSEL && PENABLE && !PREADY |=> PREADY)
    else $error("pready not one wait state");
  chk_ack_value: assert property (NV_STORE && NV_STORE_OK |-> TX_SEND && TX_VALUE == $past(CAL_VALUE))
    else $error("calibration not acknowledged");
  chk_store_cause: assert property (NV_STORE && NV_STORE_OK |-> $past(CAL_VALID))
    else $error("store without telegram");
  chk_store_ok: assert property (NV_STORE |-> NV_STORE_OK == $past(CAL_VALID))
    else $error("stored calibration validity wrong");
  chk_cal_window: assert property (CAL_VALID && far |=> !NV_STORE)
    else $error("far calibration accepted");
  chk_store_ofs: assert property (NV_STORE && NV_STORE_OK |-> NV_STORE_OFS == $past(CAL_VALUE) - $past(raw_q))
    else $error("learned offset wrong");
  chk_read_cause: assert property (READ_RESP |-> $past(READ_REQ))
    else $error("read answer unsolicited");
  chk_tx_hold: assert property (!TX_SEND |-> $stable(TX_VALUE))
    else $error("object value moved between sends");
endmodule

bind rtm_top rtm_top_props #(.MINUTE_CYC(MINUTE_CYC)) u_props (
  .CLK(CLK), .RST(RST), .PSEL(PSEL), .PENABLE(PENABLE), .PREADY(PREADY),
  .SENSOR_VALID(SENSOR_VALID), .SENSOR_TEMP(SENSOR_TEMP), .CAL_VALID(CAL_VALID),
  .CAL_VALUE(CAL_VALUE), .READ_REQ(READ_REQ), .NV_STORE(NV_STORE), .NV_STORE_OK(NV_STORE_OK),
  .NV_STORE_OFS(NV_STORE_OFS), .TX_SEND(TX_SEND), .TX_VALUE(TX_VALUE), .READ_RESP(READ_RESP));

// [testbench/rtm_knx_peer.sv]
/*
  bus peer: commissioning tool and subscribers sending telegrams.
  assumes strobes are sampled at the rising clock edge.
*/
`timescale 1ns/100ps
module rtm_knx_peer (
  input  wire        CLK,
  output reg         CAL_VALID,
  output reg  [15:0] CAL_VALUE,
  output reg         READ_REQ
);
  // idle lines at time zero
  initial begin
    CAL_VALID = 1'b0;
    CAL_VALUE = 16'h0000;
    READ_REQ  = 1'b0;
  end
  // one 2-byte reference, then the data line shows garbage
  task calib(input [15:0] v);
    @(posedge CLK);
    CAL_VALID <= 1'b1;
    CAL_VALUE <= v;
    @(posedge CLK);
    CAL_VALID <= 1'b0;
    CAL_VALUE <= ~v;
  endtask
  // one read telegram
  task read_req;
    @(posedge CLK);
    READ_REQ <= 1'b1;
    @(posedge CLK);
    READ_REQ <= 1'b0;
  endtask
endmodule

// [testbench/rtm_top_tb.sv]
/*
  bench for rtm_top: apb setup, samples, startup and telegrams.
  assumes rtm_knx_peer on the bus side and a 20-cycle minute.
*/
`timescale 1ns/100ps
`include "rtm_defs.vh"
module rtm_top_tb;
  reg         clk, rst, psel, penable, pwrite, s_valid, startup, slv, nv_load, nv_ok;
  reg  [7:0]  paddr;
  reg  [31:0] pwdata, rd;
  reg  [15:0] s_temp, tx_v, rd_v, nv_ofs;
  wire [31:0] prdata;
  wire        pready, pslverr, cal_valid, read_req, tx_send, read_resp, nv_store, nv_store_ok;
  wire [15:0] cal_value, tx_value, read_value, nv_store_ofs;
  integer     err_total, n_compared, seed, tx_n, rd_n, raw, ofs, lrn, i;

  rtm_top #(.MINUTE_CYC(32'h0000_0014)) dut (
    .CLK(clk), .RST(rst), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
    .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
    .PSLVERR(pslverr), .SENSOR_VALID(s_valid), .SENSOR_TEMP(s_temp),
    .STARTUP(startup), .CAL_VALID(cal_valid), .CAL_VALUE(cal_value),
    .READ_REQ(read_req), .NV_LOAD(nv_load), .NV_LOAD_OK(nv_ok), .NV_LOAD_OFS(nv_ofs),
    .NV_STORE(nv_store), .NV_STORE_OK(nv_store_ok), .NV_STORE_OFS(nv_store_ofs), .TX_SEND(tx_send),
    .TX_VALUE(tx_value), .READ_RESP(read_resp), .READ_VALUE(read_value));
  rtm_knx_peer peer (.CLK(clk), .CAL_VALID(cal_valid), .CAL_VALUE(cal_value), .READ_REQ(read_req));

  // clock and watchdog
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  initial begin
    #300000;
    err_total = err_total + 1;
    end_sim;
  end
  // capture telegrams and read answers
  always @(posedge clk) begin
    if (tx_send === 1'b1) begin
      tx_n = tx_n + 1;
      tx_v = tx_value;
    end
    if (read_resp === 1'b1) begin
      rd_n = rd_n + 1;
      rd_v = read_value;
    end
    if (nv_store === 1'b1) begin
      nv_ok  <= nv_store_ok; // persistent store model
      nv_ofs <= nv_store_ofs;
    end
  end

  task cmp(input [31:0] got, input [31:0] exp);
    n_compared = n_compared + 1;
    if (got !== exp) begin
      err_total = err_total + 1;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // one apb transfer, held until pready
  task apb(input w, input [7:0] a, input [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1)
      @(posedge clk);
    rd = prdata;
    slv = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task rchk(input [7:0] a, input [31:0] e);
    apb(1'b0, a, 32'h0000_0000);
    cmp(rd, e);
  endtask
  // raw sample and startup strobes
  task sample(input integer v);
    @(posedge clk);
    s_valid <= 1'b1;
    s_temp <= v[15:0];
    raw = v;
    @(posedge clk);
    s_valid <= 1'b0;
    s_temp <= ~v[15:0];
  endtask
  task boot;
    @(posedge clk);
    startup <= 1'b1;
    @(posedge clk);
    startup <= 1'b0;
  endtask
  // next telegram must carry e
  task exp_tx(input integer e);
    integer n0, n;
    n0 = tx_n;
    n = 0;
    while (tx_n == n0 && n < 60) begin
      @(posedge clk);
      #1;
      n = n + 1;
    end
    cmp(tx_n, n0 + 1);
    cmp(tx_v, e[15:0]);
  endtask
  task quiet(input integer c);
    integer n0;
    n0 = tx_n;
    repeat (c) @(posedge clk);
    #1;
    cmp(tx_n, n0);
  endtask
  task rdq(input integer k);
    integer n0;
    n0 = rd_n;
    peer.read_req;
    repeat (2) @(posedge clk);
    #1;
    cmp(rd_n, n0 + k);
  endtask
  task end_sim;
    $display("compared %0d errors %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  // main sequence
  initial begin
    rst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    s_valid = 1'b0;
    s_temp = 16'h0000;
    startup = 1'b0;
    nv_load = 1'b0;
    nv_ok = 1'b0;
    nv_ofs = 16'h0000;
    {err_total, n_compared, tx_n, rd_n} = 0;
    seed = 19;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    for (i = 0; i < 7; i = i + 1)
      rchk({i[5:0], 2'b00}, 32'h0000_0000);
    rchk(8'h1C, 32'h0000_0000);
    cmp(slv, 1'b1);
    raw = 2000 + {$random(seed)} % 1000;
    sample(raw);
    boot;
    quiet(10);
    apb(1'b1, `RTM_A_OFFSET, 32'h0000_0BB8);
    rchk(`RTM_A_OFFSET, 32'h0000_0BB8);
    ofs = 2000;
    apb(1'b1, `RTM_A_STEP, 32'h0000_0001);
    apb(1'b1, `RTM_A_CTRL, 32'h0000_0001);
    sample(raw);
    exp_tx(raw + ofs);
    boot;
    exp_tx(raw + ofs);
    sample(raw + 5);
    quiet(8);
    sample(raw + 7);
    exp_tx(raw + ofs);
    rdq(0);
    apb(1'b1, `RTM_A_CTRL, 32'h0000_0009);
    rdq(1);
    cmp(rd_v, raw + ofs);
    apb(1'b1, `RTM_A_CTRL, 32'h0000_000F);
    apb(1'b1, `RTM_A_CYCLE, 32'h0000_0001);
    exp_tx(16'h7FFF);
    apb(1'b1, `RTM_A_CYCLE, 32'h0000_0000);
    peer.calib(raw + 10001);
    quiet(5);
    rchk(`RTM_A_STATUS, 32'h0000_0004);
    lrn = {$random(seed)} % 2000;
    peer.calib(raw + lrn);
    exp_tx(raw + lrn);
    rchk(`RTM_A_STATUS, 32'h0000_0009);
    rchk(`RTM_A_LEARNED, lrn);
    sample(raw + 100);
    exp_tx(raw + lrn);
    apb(1'b1, `RTM_A_CYCLE, 32'h0000_0001);
    for (i = 0; i < 2; i = i + 1)
      exp_tx(raw + lrn);
    cmp(nv_ok, 1'b1);
    cmp(nv_ofs, lrn);
    // supply loss: reset, then restore from the persistent copy
    @(posedge clk);
    rst <= 1'b1;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    nv_load <= 1'b1;
    @(posedge clk);
    nv_load <= 1'b0;
    rchk(`RTM_A_STATUS, 32'h0000_0001);
    rchk(`RTM_A_LEARNED, lrn);
    apb(1'b1, `RTM_A_CTRL, 32'h0000_000F);
    sample(raw);
    rchk(`RTM_A_OBJECT, raw + lrn);
    apb(1'b1, `RTM_A_CTRL, 32'h0000_0009);
    apb(1'b1, `RTM_A_CYCLE, 32'h0000_0000);
    rchk(`RTM_A_STATUS, 32'h0000_0008);
    cmp(nv_ok, 1'b0);
    peer.calib(raw);
    quiet(5);
    end_sim;
  end
endmodule
